/* common/oc_pkg.sv */
package oc_pkg;
    // port select values
    localparam logic       port_command       = 1'b0;
    localparam logic       port_mask          = 1'b1;
    // command word type field, bits 4 and 3
    localparam int         word_type_hi       = 4;
    localparam int         word_type_lo       = 3;
    localparam logic [1:0] type_end_rotate    = 2'b00;
    localparam logic [1:0] type_mode_select   = 2'b01;
    // end-and-rotate word fields
    localparam int         rotate_pos         = 7;
    localparam int         specific_pos       = 6;
    localparam int         eoi_pos            = 5;
    localparam int         level_hi           = 2;
    // mode word fields
    localparam int         smm_enable_pos     = 6;
    localparam int         smm_pos            = 5;
    localparam int         poll_pos           = 2;
    localparam int         read_reg_pos       = 1;
    localparam int         in_service_pos     = 0;
    // reset values
    localparam logic [7:0] mask_reset         = 8'h00;
    localparam logic [2:0] lowest_reset       = 3'h7;
    // poll answer layout
    localparam int         poll_flag_pos      = 7;
    // read source selection
    typedef enum logic [1:0] {
        read_request,
        read_in_service,
        read_poll
    } read_sel_t;
endpackage : oc_pkg

/* design/priority_pick.sv */
`timescale 1ns/1ps
// finds the highest-priority set bit given the current lowest level
module priority_pick #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0]         bits,
    input  wire logic [$clog2(WIDTH)-1:0] lowest,
    output logic                          found,
    output logic [$clog2(WIDTH)-1:0]      level
);
    localparam int LW = $clog2(WIDTH);

    // scan down from the lowest level, wrapping round; the last hit, nearest after the lowest, wins
    always_comb
    begin
        logic [LW-1:0] idx;
        found = 1'b0;
        level = '0;
        idx   = '0;
        for (int i = WIDTH - 1; i >= 0; i--)
        begin
            idx = LW'(lowest + LW'(1) + LW'(i));
            if (bits[idx])
            begin
                found = 1'b1;
                level = idx;
            end
        end
    end
endmodule : priority_pick

/* design/interrupt_operational_commands.sv */
`timescale 1ns/1ps
// Function
// R1: command words accepted anytime, any order
// R2: mask port write loads mask; read returns
// R3: mask one blocks input n, zero enables
// R4: mask read back with identical bit meaning
// R5: command port bits 4,3 pick word type
// R6: 1,0,0 enables, 0,0,0 disables auto rotation
// R7: nonspecific end clears highest; 1,0,1 also rotates
// R8: specific end clears named; 1,1,1 rotates; 0,1,0 nothing
// R9: 1,1,0 sets priority from level field
// R10: level field used only when specific set
// R11: special mask follows bit when enable set
// R12: poll bit issues poll, beats register read
// R13: register read selects in-service or request
// R14: host reaches ports at base offsets
// R15: after init: request select, input 0 highest
// R16: host disables interrupts while issuing words
// R17: poll read returns flag and highest level
// R18: rotation makes serviced level lowest priority
// R19: read selection persists until next read word
module interrupt_operational_commands #(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             init_start,
    input  wire logic             write_strobe,
    input  wire logic             read_strobe,
    input  wire logic             port_select_line,
    input  wire logic [7:0]       write_data,
    output logic      [7:0]       read_data,
    input  wire logic [WIDTH-1:0] pending_request_register,
    input  wire logic             acknowledge,
    input  wire logic             auto_end_of_interrupt,
    output logic      [WIDTH-1:0] request_mask_register,
    output logic      [WIDTH-1:0] in_service_register,
    output logic      [WIDTH-1:0] enabled_requests,
    output logic      [2:0]       lowest_level,
    output logic                  special_mask_mode,
    output logic                  auto_rotate,
    output logic                  irq_pending,
    output logic      [2:0]       irq_level
);
    localparam int LW = $clog2(WIDTH);

    // state registers
    logic [WIDTH-1:0]       mask_reg;     // request mask
    logic [WIDTH-1:0]       isr_reg;      // in-service bits
    logic [LW-1:0]          lowest_reg;   // lowest priority level
    logic                   smm_reg;      // special mask mode
    logic                   rot_reg;      // rotate in auto end
    oc_pkg::read_sel_t      sel_reg;      // persistent read select
    logic                   poll_reg;     // poll armed for next read
    logic [7:0]             rdata_reg;    // registered read data

    // decode of the write strobe
    wire cmd_wr  = write_strobe && port_select_line == oc_pkg::port_command;
    wire mask_wr = write_strobe && port_select_line == oc_pkg::port_mask;
    wire [1:0] wtype = write_data[oc_pkg::word_type_hi:oc_pkg::word_type_lo];
    wire er_wr   = cmd_wr && wtype == oc_pkg::type_end_rotate;   // [R5]
    wire ms_wr   = cmd_wr && wtype == oc_pkg::type_mode_select;  // [R5]

    // end-and-rotate word flags
    wire f_rot   = write_data[oc_pkg::rotate_pos];
    wire f_sl    = write_data[oc_pkg::specific_pos];
    wire f_eoi   = write_data[oc_pkg::eoi_pos];
    wire [2:0] f_level = write_data[oc_pkg::level_hi:0];
    wire [2:0] flags   = {f_rot, f_sl, f_eoi};

    // mode word flags
    wire f_special_mask_write_enable = write_data[oc_pkg::smm_enable_pos];
    wire f_smm  = write_data[oc_pkg::smm_pos];
    wire f_poll = write_data[oc_pkg::poll_pos];
    wire f_rr   = write_data[oc_pkg::read_reg_pos];
    wire f_ris  = write_data[oc_pkg::in_service_pos];

    // highest set in-service bit, for nonspecific end
    logic          isr_found;
    logic [LW-1:0] isr_top;
    priority_pick #(.WIDTH(WIDTH)) u_isr_pick (
        .bits   (isr_reg),
        .lowest (lowest_reg),
        .found  (isr_found),
        .level  (isr_top)
    );

    // highest unmasked pending request, for poll and outputs
    wire [WIDTH-1:0] req_ok = pending_request_register & ~mask_reg; // [R3]
    logic          req_found;
    logic [LW-1:0] req_top;
    priority_pick #(.WIDTH(WIDTH)) u_req_pick (
        .bits   (req_ok),
        .lowest (lowest_reg),
        .found  (req_found),
        .level  (req_top)
    );

    // end-of-interrupt and rotation decode
    wire do_ns_eoi = er_wr && flags[1:0] == 2'b01;              // [R7]
    wire do_sp_eoi = er_wr && flags[1:0] == 2'b11;              // [R8]
    wire do_setpri = er_wr && flags == 3'b110;                  // [R9]
    // level field only matters when specific flag set
    wire [LW-1:0] ns_level = isr_top;                           // [R10]
    wire [LW-1:0] sp_level = LW'(f_level);                      // [R10]
    wire [WIDTH-1:0] clr_ns = (do_ns_eoi && isr_found) ?
                              (WIDTH'(1) << ns_level) : '0;
    wire [WIDTH-1:0] clr_sp = do_sp_eoi ? (WIDTH'(1) << sp_level) : '0;
    // poll read acts as acknowledge of the top request
    wire poll_rd = read_strobe && poll_reg &&
                   port_select_line == oc_pkg::port_command;     // [R17]
    wire ack_any = (acknowledge || poll_rd) && req_found;
    wire [WIDTH-1:0] set_ack = (ack_any && !auto_end_of_interrupt) ?
                               (WIDTH'(1) << req_top) : '0;

    // next lowest-priority level, rotation makes serviced level lowest
    logic [LW-1:0] lowest_next;
    always_comb
    begin
        lowest_next = lowest_reg;
        if (do_ns_eoi && f_rot && isr_found)
            lowest_next = ns_level;                             // [R7] [R18]
        else if (do_sp_eoi && f_rot)
            lowest_next = sp_level;                             // [R8] [R18]
        else if (do_setpri)
            lowest_next = sp_level;                             // [R9]
        else if (ack_any && auto_end_of_interrupt && rot_reg)
            lowest_next = req_top;                              // [R18]
    end

    // mask register, written any time
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            mask_reg <= oc_pkg::mask_reset;
        else if (init_start)
            mask_reg <= oc_pkg::mask_reset;
        else if (mask_wr)
            mask_reg <= write_data[WIDTH-1:0];                  // [R2] [R1]
    end

    // in-service bits: acknowledge sets win over end clears
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            isr_reg <= '0;
        else if (init_start)
            isr_reg <= '0;
        else
            isr_reg <= (isr_reg & ~(clr_ns | clr_sp)) | set_ack; // [R7] [R8]
    end

    // priority base
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            lowest_reg <= LW'(oc_pkg::lowest_reset);
        else if (init_start)
            lowest_reg <= LW'(oc_pkg::lowest_reset);            // [R15]
        else
            lowest_reg <= lowest_next;
    end

    // automatic rotation enable
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            rot_reg <= 1'b0;
        else if (init_start)
            rot_reg <= 1'b0;
        else if (er_wr && flags[1:0] == 2'b00)
            rot_reg <= f_rot;                                   // [R6]
    end

    // special mask mode
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            smm_reg <= 1'b0;
        else if (init_start)
            smm_reg <= 1'b0;
        else if (ms_wr && f_special_mask_write_enable)
            smm_reg <= f_smm;                                   // [R11]
    end

    // read selection and poll arming
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            sel_reg  <= oc_pkg::read_request;
            poll_reg <= 1'b0;
        end
        else if (init_start)
        begin
            sel_reg  <= oc_pkg::read_request;                   // [R15]
            poll_reg <= 1'b0;
        end
        else if (ms_wr && f_poll)
            poll_reg <= 1'b1;                                   // [R12]
        else if (ms_wr && f_rr)
            sel_reg  <= f_ris ? oc_pkg::read_in_service
                              : oc_pkg::read_request;           // [R13] [R19]
        else if (poll_rd || (read_strobe &&
                 port_select_line == oc_pkg::port_command))
            poll_reg <= 1'b0;                                   // [R17]
    end

    // read source selection
    wire [7:0] poll_word = {req_found, 4'h0, 3'(req_top)};      // [R17]
    logic [7:0] rdata_next;
    always_comb
    begin
        rdata_next = rdata_reg;
        if (read_strobe)
        begin
            if (port_select_line == oc_pkg::port_mask)
                rdata_next = 8'(mask_reg);                      // [R2] [R4]
            else if (poll_reg)
                rdata_next = poll_word;                         // [R17]
            else if (sel_reg == oc_pkg::read_in_service)
                rdata_next = 8'(isr_reg);                       // [R13]
            else
                rdata_next = 8'(pending_request_register);      // [R13]
        end
    end

    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    // outputs
    assign read_data             = rdata_reg;
    assign request_mask_register = mask_reg;
    assign in_service_register   = isr_reg;
    assign enabled_requests      = req_ok;                      // [R3]
    assign lowest_level          = 3'(lowest_reg);
    assign special_mask_mode     = smm_reg;
    assign auto_rotate           = rot_reg;
    assign irq_pending           = req_found;
    assign irq_level             = 3'(req_top);
endmodule : interrupt_operational_commands

/* bench/oc_checker.sv */
`timescale 1ns/1ps
// port watcher for the command decoder
module oc_checker #(
    parameter int WIDTH = 8
) (
    input wire logic             sys_clk,
    input wire logic             reset,
    input wire logic             init_start,
    input wire logic             write_strobe,
    input wire logic             read_strobe,
    input wire logic             port_select_line,
    input wire logic [7:0]       write_data,
    input wire logic [7:0]       read_data,
    input wire logic [WIDTH-1:0] pending_request_register,
    input wire logic             acknowledge,
    input wire logic [WIDTH-1:0] request_mask_register,
    input wire logic [WIDTH-1:0] in_service_register,
    input wire logic [WIDTH-1:0] enabled_requests,
    input wire logic [2:0]       lowest_level,
    input wire logic             special_mask_mode,
    input wire logic             auto_rotate
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    // command port write, no init in the way; q adds no ack and no read
    wire       cw = write_strobe && !port_select_line && !init_start;
    wire       q  = !acknowledge && !read_strobe;
    wire       e2 = cw && write_data[4:3] == 2'b00;
    wire       e3 = cw && write_data[4:3] == 2'b01;
    wire [2:0] f  = write_data[7:5];
    a_mask_load: assert property (
        write_strobe && port_select_line && !init_start
        |=> request_mask_register == $past(write_data))
        else $error("mask not loaded");
    a_mask_gate: assert property (
        enabled_requests ==
        (pending_request_register & ~request_mask_register))
        else $error("mask gating wrong");
    a_mask_read: assert property (
        read_strobe && port_select_line
        |=> read_data == $past(request_mask_register))
        else $error("mask read wrong");
    a_rotate_on: assert property (
        e2 && f == 3'h4 |=> auto_rotate)
        else $error("rotation not enabled");
    a_rotate_off: assert property (
        e2 && f == 3'h0 |=> !auto_rotate)
        else $error("rotation not disabled");
    a_level_set: assert property (
        e2 && f == 3'h6 |=> lowest_level == $past(write_data[2:0]))
        else $error("priority not set");
    a_noop_hold: assert property (
        e2 && f == 3'h2 && q
        |=> $stable(in_service_register) && $stable(lowest_level))
        else $error("no-op changed state");
    a_spec_clear: assert property (
        e2 && f == 3'h3 && q
        |=> !in_service_register[$past(write_data[2:0])])
        else $error("specific end missed");
    a_smm_follow: assert property (
        e3 && write_data[6]
        |=> special_mask_mode == $past(write_data[5]))
        else $error("special mask not set");
    a_smm_keep: assert property (
        e3 && !write_data[6] |=> $stable(special_mask_mode))
        else $error("special mask moved");
    // main scenarios reached
    c_rot_end: cover property (e2 && f == 3'h5);
    c_poll: cover property (e3 && write_data[2]);
    c_mask_rd: cover property (read_strobe && port_select_line);
    c_auto_rot: cover property (acknowledge && auto_rotate);
endmodule : oc_checker

bind interrupt_operational_commands oc_checker #(.WIDTH(WIDTH)) chk (.*);

/* bench/req_source.sv */
`timescale 1ns/1ps
// interrupting devices plus the cpu acknowledge
module req_source (
    input  wire logic       sys_clk,
    output logic      [7:0] pending,
    output logic            ack,
    output logic            auto_end
);
    initial
    begin
        pending = 8'h00;
        ack = 1'b0;
        auto_end = 1'b0;
    end
    // new request pattern, off the sampling edge
    task automatic raise(input logic [7:0] bits);
        @(negedge sys_clk);
        pending = bits;
        // let the combinational outputs settle before any check
        #1;
    endtask : raise
    // automatic end mode level, off the sampling edge
    task automatic set_auto(input logic on);
        @(negedge sys_clk);
        auto_end = on;
    endtask : set_auto
    // one-cycle acknowledge of the top request
    task automatic take();
        @(negedge sys_clk);
        ack = 1'b1;
        @(negedge sys_clk);
        ack = 1'b0;
    endtask : take
endmodule : req_source

/* bench/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
    n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb;
    logic sys_clk, reset, init_start;                 // set at time zero
    logic write_strobe, read_strobe, port_select_line;
    logic [7:0] write_data, read_data, pending_request_register;
    logic [7:0] request_mask_register, in_service_register, enabled_requests;
    logic [2:0] lowest_level, irq_level;
    logic acknowledge, auto_end_of_interrupt, special_mask_mode;
    logic auto_rotate, irq_pending;
    // mask, priority base and rotation packed for reset and init checks
    wire  [11:0] base_state = {request_mask_register, lowest_level,
                               auto_rotate};
    int   n_errors = 0;
    int   cmp_count = 0;
    always #2 sys_clk = ~sys_clk;
    req_source src (.sys_clk(sys_clk), .pending(pending_request_register),
        .ack(acknowledge), .auto_end(auto_end_of_interrupt));
    interrupt_operational_commands #(.WIDTH(8)) dut (.*);
    // host write at either port, never during an acknowledge
    task automatic wr(input logic sel, input logic [7:0] d);
        @(negedge sys_clk);
        port_select_line = sel;
        write_data = d;
        write_strobe = 1'b1;
        @(negedge sys_clk);
        write_strobe = 1'b0;
    endtask : wr
    // host read, compared once read_data has settled
    task automatic rd(input logic sel, input logic [7:0] ex);
        @(negedge sys_clk);
        port_select_line = sel;
        read_strobe = 1'b1;
        @(negedge sys_clk);
        read_strobe = 1'b0;
        @(negedge sys_clk);
        `CHK("read_data", ex, read_data)
    endtask : rd
    // verdict and end of run
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // hang guard
    initial
    begin
        #20000;
        n_errors++;
        results();
    end
    initial
    begin
        sys_clk = 1'b0;
        reset = 1'b1;
        init_start = 1'b0;
        write_strobe = 1'b0;
        read_strobe = 1'b0;
        port_select_line = 1'b0;
        write_data = 8'h00;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        reset = 1'b0;
        `CHK("state", {8'h00, 3'h7, 1'b0}, base_state)
        wr(1'b1, 8'ha5);
        src.raise(8'hff);
        `CHK("enabled", 8'h5a, enabled_requests)
        rd(1'b1, 8'ha5);
        rd(1'b0, 8'hff);
        wr(1'b1, 8'h00);
        src.raise(8'h08);
        src.take();
        wr(1'b0, 8'h0b);
        rd(1'b0, 8'h08);
        rd(1'b0, 8'h08);
        src.raise(8'h04);
        wr(1'b0, 8'h0e);
        rd(1'b0, 8'h82);
        rd(1'b0, 8'h0c);
        $display("test reads done");
        wr(1'b0, 8'h27);
        `CHK("isr", 8'h08, in_service_register)
        wr(1'b0, 8'h47);
        `CHK("isr", 8'h08, in_service_register)
        wr(1'b0, 8'h63);
        `CHK("isr", 8'h00, in_service_register)
        wr(1'b0, 8'hc4);
        src.raise(8'h21);
        `CHK("level", {3'h4, 3'h5}, {lowest_level, irq_level})
        src.raise(8'h40);
        src.take();
        wr(1'b0, 8'ha0);
        `CHK("rot", {8'h00, 3'h6}, {in_service_register, lowest_level})
        src.raise(8'h02);
        src.take();
        wr(1'b0, 8'he1);
        `CHK("rot", {8'h00, 3'h1}, {in_service_register, lowest_level})
        $display("test end commands done");
        wr(1'b0, 8'h80);
        `CHK("rotate", 1'b1, auto_rotate)
        wr(1'b0, 8'h00);
        `CHK("rotate", 1'b0, auto_rotate)
        wr(1'b0, 8'h68);
        wr(1'b0, 8'h08);
        `CHK("smm", 1'b1, special_mask_mode)
        wr(1'b0, 8'h48);
        `CHK("smm", 1'b0, special_mask_mode)
        src.set_auto(1'b1);
        wr(1'b0, 8'h80);
        src.raise(8'h10);
        src.take();
        `CHK("auto_end_of_interrupt isr", 8'h00, in_service_register)
        `CHK("auto_end_of_interrupt level", 3'h4, lowest_level)
        `CHK("pending", 1'b1, irq_pending)
        src.set_auto(1'b0);
        src.raise(8'h02);
        wr(1'b1, 8'h3c);
        @(negedge sys_clk);
        init_start = 1'b1;
        @(negedge sys_clk);
        init_start = 1'b0;
        `CHK("init", {8'h00, 3'h7, 1'b0}, base_state)
        rd(1'b0, 8'h02);
        $display("test modes done");
        results();
    end
endmodule : tb
